/* hw/cacr_pkg.sv */
// Package for the clock analog configuration register bank.
// Assumes a byte-wide register index/data access port from the serial processor port.
package cacr_pkg;

    // Register indices (byte-wide registers, multi-byte registers span several indices)
    localparam logic [4:0] IDX_REF_DIV     = 5'h00;
    localparam logic [4:0] IDX_FB_MOD      = 5'h01;
    localparam logic [4:0] IDX_FB_INT      = 5'h02;
    localparam logic [4:0] IDX_FB_FRAC_LO  = 5'h03;
    localparam logic [4:0] IDX_FB_FRAC_HI  = 5'h04;
    localparam logic [4:0] IDX_DAC_SET     = 5'h05;
    localparam logic [4:0] IDX_SYS_DIV     = 5'h06;
    localparam logic [4:0] IDX_BIAS_LO     = 5'h07;
    localparam logic [4:0] IDX_BIAS_HI     = 5'h08;
    localparam logic [4:0] IDX_XO_B0       = 5'h09;
    localparam logic [4:0] IDX_XO_B1       = 5'h0a;
    localparam logic [4:0] IDX_XO_B2       = 5'h0b;
    localparam logic [4:0] IDX_XO_B3       = 5'h0c;
    localparam logic [4:0] IDX_OD_LO       = 5'h0d;
    localparam logic [4:0] IDX_OD_HI       = 5'h0e;
    localparam logic [4:0] IDX_DRV_EN      = 5'h0f;
    localparam logic [4:0] IDX_DRV_MODE    = 5'h10;
    localparam logic [4:0] IDX_DRV_AMP     = 5'h11;

    // Writable masks per byte
    localparam logic [7:0] MSK_REF_DIV  = 8'h07;
    localparam logic [7:0] MSK_FB_MOD   = 8'h83;
    localparam logic [7:0] MSK_DAC_SET  = 8'h1f;
    localparam logic [7:0] MSK_SYS_DIV  = 8'h1f;
    localparam logic [7:0] MSK_XO_B2    = 8'h07;
    localparam logic [7:0] MSK_OD_HI    = 8'hbf;
    localparam logic [7:0] MSK_DRV_EN   = 8'h0f;

    // Reset values
    localparam logic [2:0]  RST_REF_DIV   = 3'h1;
    localparam logic        RST_MOD_ON    = 1'b1;
    localparam logic [1:0]  RST_MOD_ORDER = 2'h1;
    localparam logic [7:0]  RST_FB_INT    = 8'h23;
    localparam logic [15:0] RST_FB_FRAC   = 16'h2800;
    localparam logic [4:0]  RST_DAC_SET   = 5'h04;
    localparam logic [4:0]  RST_SYS_DIV   = 5'h0c;
    localparam logic [18:0] RST_XO        = 19'h15f1f;
    localparam logic [15:0] RST_OD        = 16'h8069;
    localparam logic [3:0]  RST_DRV_EN    = 4'h0;
    localparam logic [7:0]  RST_DRV_MODE  = 8'h6c;
    localparam logic [7:0]  RST_DRV_AMP   = 8'hb4;

    // Codes
    localparam logic [1:0] ORDER_INT  = 2'h0;
    localparam logic [1:0] ORDER_RSVD = 2'h3;
    localparam logic [4:0] DAC_MAX    = 5'h10;
    localparam logic [5:0] CAP_MAX    = 6'h2f;
    localparam logic [2:0] REF_DIV_MAX = 3'h4;
    localparam int unsigned SYS_PRE_DIV = 4;

    typedef enum logic [1:0] {
        CACR_HCSL = 2'h0,
        CACR_RSVD = 2'h1,
        CACR_LVDS = 2'h2,
        CACR_CMOS = 2'h3
    } cacr_drv_type_t;

    typedef enum logic [1:0] {
        CACR_DIS_LOW_LOW  = 2'h0,
        CACR_DIS_LOW_HIGH = 2'h1,
        CACR_DIS_HIZ      = 2'h2,
        CACR_DIS_TOGGLE   = 2'h3
    } cacr_dis_state_t;

    // Bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] idx;
        logic [7:0] wdata;
    } cacr_req_t;

    // Bias calibration inputs
    typedef struct packed {
        logic       comp_level;
        logic [2:0] cfg_eff;
        logic [2:0] cfg_sel;
        logic       fail;
        logic       done;
    } cacr_bias_t;

    // Complete register state
    typedef struct packed {
        logic [2:0]  ref_div;
        logic        mod_on;
        logic [1:0]  mod_order;
        logic [7:0]  fb_int;
        logic [15:0] fb_frac;
        logic [4:0]  dac_set;
        logic [4:0]  sys_div;
        logic [18:0] xo;
        logic [15:0] od;
        logic [3:0]  drv_en;
        logic [7:0]  drv_mode;
        logic [7:0]  drv_amp;
        logic [7:0]  rdata;
    } cacr_state_t;

endpackage

/* hw/cacr_regs.sv */
// Configuration and status register bank for the converter APLL, system divider,
// bias calibration, crystal oscillator and output stage.
// Assumes a synchronous byte-wide index/data port driven by the serial port logic.
`timescale 1ns/1ps
`default_nettype none

module cacr_regs
    import cacr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire cacr_req_t   req,
    output logic [7:0]       rdata,
    input  wire cacr_bias_t  bias,
    input  wire logic        osc_clk,
    input  wire logic        out_enable_pin,
    output logic [2:0]       ref_div_code,
    output logic [4:0]       ref_div_ratio,
    output logic             fb_mmd_mode,
    output logic [1:0]       fb_mod_order,
    output logic [23:0]      fb_ratio_q8_16,
    output logic [4:0]       dac_base,
    output logic [4:0]       sys_div,
    output logic [1:0]       crystal_gain_amps,
    output logic [5:0]       cap_xout,
    output logic [5:0]       cap_xin,
    output logic             crystal_regulator_on,
    output logic             divider_regulator_on,
    output logic [13:0]      outdiv_ratio,
    output cacr_drv_type_t   drv_type,
    output logic [1:0]       lvds_common_level,
    output logic             hcsl_term_on,
    output logic             drv_bias_on,
    output logic [3:0]       swing_code,
    output logic             lvds_amp_high,
    output logic             clock_out_true,
    output logic             clock_out_true_oe,
    output logic             clock_out_complement,
    output logic             clock_out_complement_oe
);

    cacr_state_t st_reg;
    cacr_state_t st_next;

    // Masked byte update: only writable bits change
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                          input logic [7:0] msk);
        merge = (old & ~msk) | (nw & msk);
    endfunction

    function automatic logic [7:0] bias_byte(input cacr_bias_t b, input logic hi);
        if (hi)
        begin
            bias_byte = {7'h00, b.comp_level};
        end
        else
        begin
            // Fields shown only once calibration has finished
            bias_byte = b.done ? {b.cfg_eff, b.cfg_sel, b.fail, 1'b1}
                               : 8'h00;
        end
    endfunction

    always_comb
    begin
        st_next = st_reg;
        if (req.wr)
        begin
            case (req.idx)
                IDX_REF_DIV:    st_next.ref_div = 3'(merge({5'h00, st_reg.ref_div},
                                    req.wdata, MSK_REF_DIV));
                IDX_FB_MOD:
                begin
                    st_next.mod_on    = req.wdata[7];
                    st_next.mod_order = req.wdata[1:0];
                end
                IDX_FB_INT:     st_next.fb_int = req.wdata;
                IDX_FB_FRAC_LO: st_next.fb_frac[7:0] = req.wdata;
                IDX_FB_FRAC_HI: st_next.fb_frac[15:8] = req.wdata;
                IDX_DAC_SET:    st_next.dac_set = 5'(merge({3'h0, st_reg.dac_set},
                                    req.wdata, MSK_DAC_SET));
                IDX_SYS_DIV:    st_next.sys_div = 5'(merge({3'h0, st_reg.sys_div},
                                    req.wdata, MSK_SYS_DIV));
                IDX_XO_B0:      st_next.xo[7:0] = req.wdata;
                IDX_XO_B1:      st_next.xo[15:8] = req.wdata;
                IDX_XO_B2:      st_next.xo[18:16] = 3'(merge({5'h00, st_reg.xo[18:16]},
                                    req.wdata, MSK_XO_B2));
                IDX_OD_LO:      st_next.od[7:0] = req.wdata;
                IDX_OD_HI:      st_next.od[15:8] = merge(st_reg.od[15:8],
                                    req.wdata, MSK_OD_HI);
                IDX_DRV_EN:     st_next.drv_en = 4'(merge({4'h0, st_reg.drv_en},
                                    req.wdata, MSK_DRV_EN));
                IDX_DRV_MODE:   st_next.drv_mode = req.wdata;
                IDX_DRV_AMP:    st_next.drv_amp = req.wdata;
                default:        st_next.rdata = st_reg.rdata;
            endcase
        end
        if (req.rd)
        begin
            case (req.idx)
                IDX_REF_DIV:    st_next.rdata = {5'h00, st_reg.ref_div};
                IDX_FB_MOD:     st_next.rdata = {st_reg.mod_on, 5'h00, st_reg.mod_order};
                IDX_FB_INT:     st_next.rdata = st_reg.fb_int;
                IDX_FB_FRAC_LO: st_next.rdata = st_reg.fb_frac[7:0];
                IDX_FB_FRAC_HI: st_next.rdata = st_reg.fb_frac[15:8];
                IDX_DAC_SET:    st_next.rdata = {3'h0, st_reg.dac_set};
                IDX_SYS_DIV:    st_next.rdata = {3'h0, st_reg.sys_div};
                IDX_BIAS_LO:    st_next.rdata = bias_byte(bias, 1'b0);
                IDX_BIAS_HI:    st_next.rdata = bias_byte(bias, 1'b1);
                IDX_XO_B0:      st_next.rdata = st_reg.xo[7:0];
                IDX_XO_B1:      st_next.rdata = st_reg.xo[15:8];
                IDX_XO_B2:      st_next.rdata = {5'h00, st_reg.xo[18:16]};
                IDX_XO_B3:      st_next.rdata = 8'h00;
                IDX_OD_LO:      st_next.rdata = st_reg.od[7:0];
                IDX_OD_HI:      st_next.rdata = st_reg.od[15:8] & MSK_OD_HI;
                IDX_DRV_EN:     st_next.rdata = {4'h0, st_reg.drv_en};
                IDX_DRV_MODE:   st_next.rdata = st_reg.drv_mode;
                IDX_DRV_AMP:    st_next.rdata = st_reg.drv_amp;
                default:        st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_reg           <= '0;
            st_reg.ref_div   <= RST_REF_DIV;
            st_reg.mod_on    <= RST_MOD_ON;
            st_reg.mod_order <= RST_MOD_ORDER;
            st_reg.fb_int    <= RST_FB_INT;
            st_reg.fb_frac   <= RST_FB_FRAC;
            st_reg.dac_set   <= RST_DAC_SET;
            st_reg.sys_div   <= RST_SYS_DIV;
            st_reg.xo        <= RST_XO;
            st_reg.od        <= RST_OD;
            st_reg.drv_en    <= RST_DRV_EN;
            st_reg.drv_mode  <= RST_DRV_MODE;
            st_reg.drv_amp   <= RST_DRV_AMP;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rdata = st_reg.rdata;

    // Converter APLL controls
    assign ref_div_code  = st_reg.ref_div;
    // Ratio 1 means bypass; reserved codes above 4 also bypass
    assign ref_div_ratio = (st_reg.ref_div == 3'h0 || st_reg.ref_div > REF_DIV_MAX)
                           ? 5'h01 : 5'(5'h01 << st_reg.ref_div);
    assign fb_mmd_mode   = st_reg.mod_on;
    // Reserved order treated as integer
    assign fb_mod_order  = (st_reg.mod_on && st_reg.mod_order != ORDER_RSVD)
                           ? st_reg.mod_order : ORDER_INT;
    assign fb_ratio_q8_16 = st_reg.mod_on ? {st_reg.fb_int, st_reg.fb_frac}
                                          : {st_reg.fb_int, 16'h0000};
    assign dac_base      = (st_reg.dac_set > DAC_MAX) ? DAC_MAX : st_reg.dac_set;
    assign sys_div       = st_reg.sys_div;

    // Crystal oscillator
    assign crystal_regulator_on = st_reg.xo[16];
    assign crystal_gain_amps    = st_reg.xo[15:14];
    assign cap_xout = (st_reg.xo[13:8] > CAP_MAX) ? CAP_MAX : st_reg.xo[13:8];
    assign cap_xin  = (st_reg.xo[5:0] > CAP_MAX) ? CAP_MAX : st_reg.xo[5:0];

    // Output divider and driver settings
    assign divider_regulator_on = st_reg.od[15];
    assign outdiv_ratio         = st_reg.od[13:0];
    assign drv_type             = cacr_drv_type_t'(st_reg.drv_mode[1:0]);
    assign drv_bias_on          = st_reg.drv_mode[2];
    assign hcsl_term_on         = st_reg.drv_mode[3];
    assign lvds_common_level    = st_reg.drv_mode[5:4];
    assign swing_code           = st_reg.drv_amp[7:4];
    assign lvds_amp_high        = st_reg.drv_amp[3];

    // Pin behaviour
    logic            pd;
    logic            enabled;
    cacr_dis_state_t dis_state;
    logic [1:0]      cmos_phase;
    always_comb
    begin
        pd         = st_reg.drv_en[0];
        dis_state  = cacr_dis_state_t'(st_reg.drv_en[3:2]);
        cmos_phase = st_reg.drv_mode[7:6];
        enabled    = !st_reg.drv_en[1] && out_enable_pin;
        clock_out_true          = osc_clk;
        clock_out_complement    = ~osc_clk;
        clock_out_true_oe       = 1'b1;
        clock_out_complement_oe = 1'b1;
        if (drv_type == CACR_CMOS)
        begin
            case (cmos_phase)
                2'h0:    clock_out_complement = osc_clk;
                2'h1:    clock_out_complement = ~osc_clk;
                2'h2:    clock_out_complement = 1'b0;
                default: clock_out_true = 1'b0;
            endcase
        end
        if (pd)
        begin
            clock_out_true_oe       = 1'b0;
            clock_out_complement_oe = 1'b0;
            clock_out_true          = 1'b0;
            clock_out_complement    = 1'b0;
        end
        else if (!enabled)
        begin
            case (dis_state)
                CACR_DIS_LOW_LOW:
                begin
                    clock_out_true       = 1'b0;
                    clock_out_complement = (drv_type == CACR_LVDS);
                end
                CACR_DIS_LOW_HIGH:
                begin
                    clock_out_true       = 1'b0;
                    clock_out_complement = 1'b1;
                end
                CACR_DIS_HIZ:
                begin
                    clock_out_true          = 1'b0;
                    clock_out_complement    = 1'b0;
                    clock_out_true_oe       = 1'b0;
                    clock_out_complement_oe = 1'b0;
                end
                default:
                begin
                    clock_out_true_oe = 1'b1;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* tb/cacr_regs_sva.sv */
// Concurrent checks for the clock analog configuration register bank.
// Bound to cacr_regs from the testbench; sees only the bank's ports.
`timescale 1ns/1ps
`default_nettype none

module cacr_regs_sva
    import cacr_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire cacr_req_t   req,
    input wire logic [7:0]  rdata,
    input wire cacr_bias_t  bias,
    input wire logic [2:0]  ref_div_code,
    input wire logic [4:0]  ref_div_ratio,
    input wire logic        fb_mmd_mode,
    input wire logic [1:0]  fb_mod_order,
    input wire logic [23:0] fb_ratio_q8_16,
    input wire logic [4:0]  dac_base,
    input wire logic [4:0]  sys_div,
    input wire logic [5:0]  cap_xout,
    input wire logic [5:0]  cap_xin,
    input wire logic        clock_out_true_oe,
    input wire logic        clock_out_complement_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Byte write and byte read taken at one index
    sequence s_wr(logic [4:0] i);
        req.wr && req.idx == i;
    endsequence
    sequence s_rd(logic [4:0] i);
        req.rd && req.idx == i;
    endsequence

    a_ref_div_map: assert property (ref_div_code <= REF_DIV_MAX |->
        ref_div_ratio == (ref_div_code == 3'h0 ? 5'h01 : 5'(5'h01 << ref_div_code)))
        else $error("reference divide ratio wrong");
    a_mod_off_int: assert property (!fb_mmd_mode |->
        fb_ratio_q8_16[15:0] == 16'h0000 && fb_mod_order == ORDER_INT)
        else $error("integer feedback not constant");
    a_mod_order_wr: assert property (s_wr(IDX_FB_MOD) ##0
        (req.wdata[7] && req.wdata[1:0] != ORDER_RSVD) |=> fb_mod_order == $past(req.wdata[1:0]))
        else $error("modulator order not applied");
    a_fb_int_ratio: assert property (s_wr(IDX_FB_INT) |=>
        fb_ratio_q8_16[23:16] == $past(req.wdata))
        else $error("feedback integer part wrong");
    a_dac_clamp: assert property (s_wr(IDX_DAC_SET) |=>
        dac_base == (($past(req.wdata[4:0]) > DAC_MAX) ? DAC_MAX : $past(req.wdata[4:0])))
        else $error("dac set above limit");
    a_sysdiv_wr: assert property (s_wr(IDX_SYS_DIV) |=>
        sys_div == $past(req.wdata[4:0]))
        else $error("system divide not written");
    a_rd_sysdiv: assert property (s_rd(IDX_SYS_DIV) |=>
        rdata == {3'h0, $past(sys_div)})
        else $error("system divide readback wrong");
    a_bias_busy: assert property (s_rd(IDX_BIAS_LO) ##0 !bias.done |=>
        rdata == 8'h00)
        else $error("bias status shown while busy");
    a_bias_comp: assert property (s_rd(IDX_BIAS_HI) |=>
        rdata == {7'h00, $past(bias.comp_level)})
        else $error("comparator bit wrong");
    a_cap_clamp: assert property (s_wr(IDX_XO_B1) |=> cap_xin <= CAP_MAX &&
        cap_xout == (($past(req.wdata[5:0]) > CAP_MAX) ? CAP_MAX : $past(req.wdata[5:0])))
        else $error("tuning capacitance above limit");
    a_pd_tristate: assert property (s_wr(IDX_DRV_EN) ##0 req.wdata[0] |=>
        !clock_out_true_oe && !clock_out_complement_oe)
        else $error("powered down pins driven");
    a_reset_dflt: assert property (disable iff (1'b0) rst |=>
        sys_div == RST_SYS_DIV && ref_div_code == RST_REF_DIV
        && fb_ratio_q8_16 == {RST_FB_INT, RST_FB_FRAC})
        else $error("reset defaults not loaded");
endmodule

`default_nettype wire

/* tb/cacr_regs_tb.sv */
// Self-checking testbench for the clock analog configuration register bank.
// Drives the byte port, bias inputs and pin controls itself; binds the checker.
`timescale 1ns/1ps
`default_nettype none

module cacr_regs_tb;
    import cacr_pkg::*;
    logic            clk_sys, rst, osc_clk, out_enable_pin;
    cacr_req_t       req;
    cacr_bias_t      bias;
    logic [7:0]      rdata;
    logic [2:0]      ref_div_code;
    logic [4:0]      ref_div_ratio, dac_base, sys_div;
    logic [1:0]      fb_mod_order, crystal_gain_amps, lvds_common_level;
    logic [23:0]     fb_ratio_q8_16;
    logic [5:0]      cap_xout, cap_xin;
    logic [13:0]     outdiv_ratio;
    logic [3:0]      swing_code;
    cacr_drv_type_t  drv_type;
    logic            fb_mmd_mode, crystal_regulator_on, divider_regulator_on;
    logic            hcsl_term_on, drv_bias_on, lvds_amp_high;
    logic            clock_out_true, clock_out_true_oe;
    logic            clock_out_complement, clock_out_complement_oe;
    int              n_mismatch, total_checks, cyc;
    // Rows: index, write byte, writable mask
    logic [23:0] rows [0:18] = '{24'h00fc07, 24'h01ff83, 24'h025aff, 24'h0334ff,
        24'h0412ff, 24'h05ff1f, 24'h06ea1f, 24'h07ff00, 24'h08ff00, 24'h093fff,
        24'h0af0ff, 24'h0bff07, 24'h0cff00, 24'h0d0aff, 24'h0effbf, 24'h0ff30f,
        24'h10beff, 24'h1158ff, 24'h13ff00};
    logic [7:0] rst_exp [0:18] = '{8'h01, 8'h81, 8'h23, 8'h00, 8'h28, 8'h04, 8'h0c,
        8'h00, 8'h00, 8'h1f, 8'h5f, 8'h01, 8'h00, 8'h69, 8'h80, 8'h00, 8'h6c, 8'hb4, 8'h00};
    // Pin rows: enable byte, mode byte, {pin enable, osc}, {t_oe, c_oe, t, c}
    logic [23:0] pins [0:13] = '{24'h014330, 24'h02433c, 24'h06433d, 24'h0a4330,
        24'h0e433e, 24'h00033f, 24'h00433e, 24'h00432d, 24'h00832c, 24'h00833e,
        24'h00c32d, 24'h00431c, 24'h00021d, 24'h054330};

    cacr_regs dut_u (.clk_sys, .rst, .req, .rdata, .bias, .osc_clk, .out_enable_pin,
        .ref_div_code, .ref_div_ratio, .fb_mmd_mode, .fb_mod_order, .fb_ratio_q8_16,
        .dac_base, .sys_div, .crystal_gain_amps, .cap_xout, .cap_xin,
        .crystal_regulator_on, .divider_regulator_on, .outdiv_ratio, .drv_type,
        .lvds_common_level, .hcsl_term_on, .drv_bias_on, .swing_code, .lvds_amp_high,
        .clock_out_true, .clock_out_true_oe, .clock_out_complement,
        .clock_out_complement_oe);

    initial clk_sys = 1'b0;
    always #2 clk_sys = ~clk_sys;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t rdata %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t out %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] i, input logic [7:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, idx: i, wdata: d};
        @(posedge clk_sys);
        req <= '0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [4:0] i);
        req <= '{wr: 1'b0, rd: 1'b1, idx: i, wdata: 8'h00};
        @(posedge clk_sys);
        req <= '0;
        @(posedge clk_sys);
    endtask

    // Hang guard
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    initial
    begin
        rst = 1'b1;
        req = '0;
        bias = '0;
        osc_clk = 1'b0;
        out_enable_pin = 1'b1;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        for (int k = 0; k < 19; k++)
        begin
            rd(5'(k));
            chk_rd(rdata, rst_exp[k]);
        end
        foreach (rows[k])
        begin
            wr(rows[k][20:16], rows[k][15:8]);
            rd(rows[k][20:16]);
            chk_rd(rdata, rows[k][15:8] & rows[k][7:0]);
        end
        chk_out(fb_ratio_q8_16, 24'h5a1234);
        chk_out(24'({fb_mmd_mode, fb_mod_order}), 24'h4);
        chk_out(24'(dac_base), 24'h10);
        chk_out(24'(sys_div), 24'h0a);
        chk_out(24'({crystal_gain_amps, cap_xout, cap_xin}), 24'h3bef);
        chk_out(24'({drv_type, lvds_common_level, hcsl_term_on, drv_bias_on}), 24'h2f);
        chk_out(24'({swing_code, lvds_amp_high}), 24'h0b);
        chk_out(24'({crystal_regulator_on, divider_regulator_on, outdiv_ratio}),
            24'hff0a);
        for (int k = 0; k < 5; k++)
        begin
            wr(IDX_REF_DIV, 8'(k));
            chk_out(24'(ref_div_ratio), (k == 0) ? 24'h1 : 24'(1 << k));
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(IDX_FB_MOD, 8'h80 | 8'(k));
            chk_out(24'({fb_mmd_mode, fb_mod_order}), (k == 3) ? 24'h4 : 24'(4 + k));
        end
        wr(IDX_FB_MOD, 8'h01);
        chk_out(24'({fb_mmd_mode, fb_mod_order}), 24'h0);
        chk_out(fb_ratio_q8_16, 24'h5a0000);
        foreach (pins[k])
        begin
            out_enable_pin <= pins[k][5];
            osc_clk <= pins[k][4];
            wr(IDX_DRV_EN, pins[k][23:16]);
            wr(IDX_DRV_MODE, pins[k][15:8]);
            chk_out(24'({clock_out_true_oe, clock_out_complement_oe,
                clock_out_true_oe & clock_out_true,
                clock_out_complement_oe & clock_out_complement}), 24'(pins[k][3:0]));
        end
        bias <= '{comp_level: 1'b1, cfg_eff: 3'h3, cfg_sel: 3'h5, fail: 1'b1, done: 1'b0};
        rd(IDX_BIAS_LO);
        chk_rd(rdata, 8'h00);
        rd(IDX_BIAS_HI);
        chk_rd(rdata, 8'h01);
        bias.done <= 1'b1;
        rd(IDX_BIAS_LO);
        chk_rd(rdata, 8'h77);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        rd(IDX_SYS_DIV);
        chk_rd(rdata, 8'h0c);
        finish_test();
    end
endmodule

bind cacr_regs cacr_regs_sva chk_u (.clk_sys, .rst, .req, .rdata, .bias, .ref_div_code,
    .ref_div_ratio, .fb_mmd_mode, .fb_mod_order, .fb_ratio_q8_16, .dac_base, .sys_div,
    .cap_xout, .cap_xin, .clock_out_true_oe, .clock_out_complement_oe);

`default_nettype wire
